// file: design/secr_pkg.sv
// Package for the status enable and condition register bank.
// Assumes a command decoder outside that turns host status commands into
// one-cycle strobes carrying a register set select and a 16-bit value.
package secr_pkg;

  // ==========================================================================
  // Widths and register sets
  // ==========================================================================
  localparam int unsigned STAT_W = 16;

  typedef enum logic [1:0] {
    SECR_SET_MEAS,
    SECR_SET_QUES,
    SECR_SET_OPER,
    SECR_SET_NONE
  } secr_set_t;

  typedef enum logic [1:0] {
    SECR_KIND_ENABLE,
    SECR_KIND_COND,
    SECR_KIND_EVENT,
    SECR_KIND_RSVD
  } secr_kind_t;

  // ==========================================================================
  // Implemented mask bits per set (unused positions read as zero)
  // ==========================================================================
  localparam logic [15:0] MEAS_MASK_IMPL = 16'h7bbf;
  localparam logic [15:0] QUES_MASK_IMPL = 16'h4110;
  localparam logic [15:0] OPER_MASK_IMPL = 16'h0430;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] MASK_ALL_ONES  = 16'hffff;

  // Measurement bit positions.
  localparam int unsigned MEAS_READING_OVER_RANGE      = 0;
  localparam int unsigned MEAS_BELOW_FIRST_LOWER_BOUND = 1;
  localparam int unsigned MEAS_ABOVE_FIRST_UPPER_BOUND = 2;
  localparam int unsigned MEAS_BELOW_SECOND_LOWER_BOUND = 3;
  localparam int unsigned MEAS_ABOVE_SECOND_UPPER_BOUND = 4;
  localparam int unsigned MEAS_NEW_RESULT_READY        = 5;
  localparam int unsigned MEAS_TRACE_STORE_HAS_TWO     = 7;
  localparam int unsigned MEAS_TRACE_STORE_HALF        = 8;
  localparam int unsigned MEAS_TRACE_STORE_FULL        = 9;
  localparam int unsigned MEAS_READING_UNDER_RANGE     = 11;
  localparam int unsigned MEAS_DISTORTION_FREQ_TOO_HIGH = 12;
  localparam int unsigned MEAS_DISTORTION_FREQ_TOO_LOW = 13;
  localparam int unsigned MEAS_SHAPING_FILTER_FAULT    = 14;
  // Questionable and operation bit positions.
  localparam int unsigned QUES_TEMPERATURE = 4;
  localparam int unsigned QUES_CALIBRATION = 8;
  localparam int unsigned QUES_CMD_WARNING = 14;
  localparam int unsigned OPER_MEASURING   = 4;
  localparam int unsigned OPER_TRIGGERING  = 5;
  localparam int unsigned OPER_IDLE        = 10;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       preset;
    secr_set_t  set;
    secr_kind_t kind;
    logic [15:0] data;
  } secr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } secr_rsp_t;

endpackage : secr_pkg

// file: design/secr_set.sv
// One status register set: enable mask, condition mirror and latched events.
// Assumes condition inputs are already synchronous to MCLK.
module secr_set
  import secr_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hffff
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Control strobes.
  input  wire logic        mask_wr,
  input  wire logic [15:0] mask_wdata,
  input  wire logic        mask_clr,
  input  wire logic        event_rd,
  // Status in and out.
  input  wire logic [15:0] cond_in,
  output logic      [15:0] mask,
  output logic      [15:0] cond,
  output logic      [15:0] events,
  output logic             summary
);

  logic [15:0] cond_q;
  logic [15:0] rise;

  // ==========================================================================
  // Condition register
  // ==========================================================================
  // Condition follows the live state every cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      cond_q <= MASK_RESET;
    end else begin
      cond_q <= cond_in & IMPL; // R8
    end
  end
  assign cond = cond_q; // R7

  // Rising edges of the conditions become events.
  assign rise = cond_in & IMPL & ~cond_q;

  // ==========================================================================
  // Event register
  // ==========================================================================
  // A read clears it, but a rise in the same cycle survives the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      events <= MASK_RESET;
    end else if (event_rd) begin
      events <= rise; // R10
    end else begin
      events <= events | rise;
    end
  end

  // ==========================================================================
  // Enable mask
  // ==========================================================================
  // Preset beats a write in the same cycle; unused bits never store.
  always_ff @(posedge clk) begin
    if (rst) begin
      mask <= MASK_RESET;
    end else if (mask_clr) begin
      mask <= MASK_RESET; // R11
    end else if (mask_wr) begin
      mask <= mask_wdata & IMPL; // R1 R12
    end
  end

  // Only unmasked events reach the next set up.
  assign summary = |(events & mask); // R2 R3

  a_mask_unused: assert property (@(posedge clk) disable iff (rst) // R12
    (mask & ~IMPL) == MASK_RESET)
    else $error("unused mask bit set");
  a_event_clear: assert property (@(posedge clk) disable iff (rst) // R10
    event_rd |=> events == $past(rise))
    else $error("event read did not clear");

endmodule // secr_set

// file: design/secr_top.sv
// Status enable and condition register bank for three register sets.
// Assumes a host command decoder on MCLK delivering one-cycle command strobes
// and live condition vectors synchronous to MCLK.
//
// Contract
// R1 - A mask takes the sum of bit weights; 0 clears all, 65535 sets all.
// R2 - A zero mask bit keeps its event from setting the next summary bit.
// R3 - A one mask bit lets its set event raise the next summary bit.
// R4 - Measurement mask bits are 0-5, 7-9 and 11-14 as listed.
// R5 - Questionable mask holds only bits 4, 8 and 14; bit 15 reads zero.
// R6 - Operation mask holds only bits 4, 5 and 10.
// R7 - Each of the three sets carries a condition register.
// R8 - A condition register always mirrors the present state.
// R9 - A condition query returns the register value with set bits as ones.
// R10 - Reading an event register clears it; condition reads do not.
// R11 - Preset clears the three enable masks and nothing else.
// R12 - An enable query returns the stored mask with unused bits as zero.
// R13 - Registers are 16 bits, bit n weighing two to the n.
module secr_top
  import secr_pkg::*;
(
  // Clock and reset.
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // Host command port.
  input  secr_cmd_t        CMD,
  output secr_rsp_t        RSP,
  // Live conditions.
  input  wire logic [15:0] MEAS_COND,
  input  wire logic [15:0] QUES_COND,
  input  wire logic [15:0] OPER_COND,
  // Summary bits for the next register set up.
  output logic             MEAS_SUMMARY,
  output logic             QUES_SUMMARY,
  output logic             OPER_SUMMARY
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Implemented bits of the three sets, packed so that each pass of the
  // generate loop can slice its own mask out by index.
  localparam logic [47:0] IMPL_ALL = {OPER_MASK_IMPL, QUES_MASK_IMPL,
                                      MEAS_MASK_IMPL}; // R4 R5 R6

  // Per-set views, indexed 0 for measurement, 1 questionable, 2 operation.
  logic [2:0]  sel;
  logic [2:0]  summ;
  logic [15:0] mask_v [3];
  logic [15:0] cond_v [3];
  logic [15:0] evt_v  [3];
  logic [15:0] cin_v  [3];
  logic        is_wr;
  logic        is_rd;
  logic [15:0] next_rdata;

  // Live condition pins gathered per set so that the loop can index them.
  assign cin_v[0] = MEAS_COND;
  assign cin_v[1] = QUES_COND;
  assign cin_v[2] = OPER_COND;
  // Only enable masks are writable; a write of another kind is dropped
  // here, and a preset strobe never counts as a query.
  assign is_wr = CMD.valid & CMD.write & (CMD.kind == SECR_KIND_ENABLE);
  assign is_rd = CMD.valid & ~CMD.write & ~CMD.preset;

  // ==========================================================================
  // Register sets
  // ==========================================================================
  // Same structure per set; only the implemented bits differ.
  for (genvar g = 0; g < 3; g++) begin : g_set
    assign sel[g] = (CMD.set == secr_set_t'(g));
    secr_set #(
      .IMPL (IMPL_ALL[g*STAT_W +: STAT_W])
    ) u_set (
      .clk        (MCLK),
      .rst        (RESET),
      .mask_wr    (is_wr & sel[g]),
      .mask_wdata (CMD.data),
      .mask_clr   (CMD.valid & CMD.preset), // R11
      .event_rd   (is_rd & sel[g] & (CMD.kind == SECR_KIND_EVENT)), // R10
      .cond_in    (cin_v[g]),
      .mask       (mask_v[g]),
      .cond       (cond_v[g]),
      .events     (evt_v[g]),
      .summary    (summ[g])
    );
  end

  // Each summary is a level for the next set up; it drops as soon as the
  // event is read out or the mask bit is cleared.
  assign MEAS_SUMMARY = summ[0]; // R3
  assign QUES_SUMMARY = summ[1];
  assign OPER_SUMMARY = summ[2];

  // ==========================================================================
  // Query answer
  // ==========================================================================
  // The value goes out as a plain 16-bit word; the decimal text is formed by
  // the command layer, so bit n keeps weight two to the n.
  // A set select of three matches no loop index and so answers zero.
  always_comb begin
    next_rdata = MASK_RESET;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        case (CMD.kind)
          SECR_KIND_ENABLE: next_rdata = mask_v[i]; // R12
          SECR_KIND_COND:   next_rdata = cond_v[i]; // R9
          SECR_KIND_EVENT:  next_rdata = evt_v[i];
          default:          next_rdata = MASK_RESET;
        endcase
      end
    end
  end

  // Answer one cycle after the query, from a register.
  // The word refreshes every cycle; only the strobe says it was asked for.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      RSP <= '0;
    end else begin
      RSP.valid <= is_rd;
      RSP.data  <= next_rdata; // R13
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // An event reaches the next set up only through a set mask bit. These
  // checks start from the pins, so a summary wired past the mask shows up.
  a_mask_blocks: assert property (@(posedge MCLK) disable iff (RESET) // R2
    !CMD.valid && (evt_v[0] & mask_v[0]) == 16'h0000 &&
    (MEAS_COND & ~cond_v[0] & mask_v[0]) == 16'h0000 |=> !MEAS_SUMMARY)
    else $error("masked event raised summary");
  a_mask_passes: assert property (@(posedge MCLK) disable iff (RESET) // R3
    !CMD.valid && (OPER_COND & ~cond_v[2] & mask_v[2]) != 16'h0000 |=>
    OPER_SUMMARY)
    else $error("unmasked event did not raise summary");
  a_ques_blocks: assert property (@(posedge MCLK) disable iff (RESET) // R2
    !CMD.valid && (evt_v[1] & mask_v[1]) == 16'h0000 &&
    (QUES_COND & ~cond_v[1] & mask_v[1]) == 16'h0000 |=> !QUES_SUMMARY)
    else $error("masked questionable event raised summary");

  // Stored masks: a write lands with its unused bits dropped, and a preset
  // empties all three even when it carries write data.
  a_write_stores: assert property (@(posedge MCLK) disable iff (RESET) // R1
    is_wr && sel[0] && !CMD.preset |=> mask_v[0] == ($past(CMD.data)
    & MEAS_MASK_IMPL))
    else $error("mask write lost");
  a_preset_clears: assert property (@(posedge MCLK) disable iff (RESET) // R11
    CMD.valid && CMD.preset |=> mask_v[0] == 16'h0000 &&
    mask_v[1] == 16'h0000 && mask_v[2] == 16'h0000)
    else $error("preset left a mask set");
  a_meas_unused: assert property (@(posedge MCLK) disable iff (RESET) // R4
    (mask_v[0] & ~MEAS_MASK_IMPL) == 16'h0000)
    else $error("measurement unused bit set");
  a_ques_unused: assert property (@(posedge MCLK) disable iff (RESET) // R5
    (mask_v[1] & ~QUES_MASK_IMPL) == 16'h0000)
    else $error("questionable unused bit set");
  a_ques_top_zero: assert property (@(posedge MCLK) disable iff (RESET) // R5
    !mask_v[1][15] && !cond_v[1][15])
    else $error("questionable bit 15 set");
  a_oper_unused: assert property (@(posedge MCLK) disable iff (RESET) // R6
    (mask_v[2] & ~OPER_MASK_IMPL) == 16'h0000)
    else $error("operation unused bit set");

  // Writes aimed at a condition or event register are dropped, so the
  // masks of all three sets hold still through them.
  a_write_refused: assert property (@(posedge MCLK) disable iff (RESET) // R12
    CMD.valid && CMD.write && !CMD.preset &&
    CMD.kind != SECR_KIND_ENABLE |=> $stable(mask_v[0]) &&
    $stable(mask_v[1]) && $stable(mask_v[2]))
    else $error("refused write changed a mask");

  // Conditions follow their pins one cycle late; the edge that leaves reset
  // is skipped, because the registers were still held clear on it.
  a_cond_mirror: assert property (@(posedge MCLK) disable iff (RESET) // R8
    ##1 ($past(RESET) ||
    cond_v[0] == ($past(MEAS_COND) & MEAS_MASK_IMPL)))
    else $error("condition not mirrored");
  a_ques_mirror: assert property (@(posedge MCLK) disable iff (RESET) // R8
    ##1 ($past(RESET) ||
    cond_v[1] == ($past(QUES_COND) & QUES_MASK_IMPL)))
    else $error("questionable condition not mirrored");
  a_oper_mirror: assert property (@(posedge MCLK) disable iff (RESET) // R8
    ##1 ($past(RESET) ||
    cond_v[2] == ($past(OPER_COND) & OPER_MASK_IMPL)))
    else $error("operation condition not mirrored");

  // ==========================================================================
  // Checks on answers
  // ==========================================================================
  // A query answers on the next edge with the word it addressed; nothing
  // else may raise the strobe, or the host would take a stale word.
  a_query_answer: assert property (@(posedge MCLK) disable iff (RESET) // R9
    is_rd && sel[0] && CMD.kind == SECR_KIND_COND |=>
    RSP.valid && RSP.data == $past(cond_v[0]))
    else $error("condition query wrong");
  a_enable_query: assert property (@(posedge MCLK) disable iff (RESET) // R12
    is_rd && sel[1] && CMD.kind == SECR_KIND_ENABLE |=>
    RSP.valid && RSP.data == $past(mask_v[1]))
    else $error("enable query wrong");
  a_event_query: assert property (@(posedge MCLK) disable iff (RESET) // R10
    is_rd && sel[2] && CMD.kind == SECR_KIND_EVENT |=>
    RSP.valid && RSP.data == $past(evt_v[2]))
    else $error("event query wrong");
  a_no_set_zero: assert property (@(posedge MCLK) disable iff (RESET) // R12
    is_rd && CMD.set == SECR_SET_NONE |=> RSP.valid && RSP.data == 16'h0000)
    else $error("query of no set returned data");
  a_answer_only: assert property (@(posedge MCLK) disable iff (RESET) // R9
    !is_rd |=> !RSP.valid)
    else $error("answer without a query");

  // Main scenarios: raised summaries, a preset and two kinds of query.
  c_summary: cover property (@(posedge MCLK) MEAS_SUMMARY);
  c_oper_summary: cover property (@(posedge MCLK) OPER_SUMMARY);
  c_preset: cover property (@(posedge MCLK) CMD.valid && CMD.preset);
  c_event_read: cover property (@(posedge MCLK)
    is_rd && CMD.kind == SECR_KIND_EVENT && evt_v[2] != 16'h0000);
  c_cond_query: cover property (@(posedge MCLK)
    is_rd && CMD.kind == SECR_KIND_COND && cond_v[0] != 16'h0000);

endmodule // secr_top

// file: test/secr_host.sv
// Host model: issues status commands to the register bank and takes answers.
// Assumes the bank samples one-cycle command strobes on rising MCLK.
module secr_host
  import secr_pkg::*;
(
  // Clock.
  input  wire logic MCLK,
  // Command and answer.
  output secr_cmd_t CMD,
  input  secr_rsp_t RSP
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Command strobes
  // ==========================================================================
  // The bus starts idle.
  initial CMD = '0;

  // One strobe for one edge; idle data lines show the inverse afterwards.
  task automatic issue(input logic wr, input logic pre, input secr_set_t s,
                       input secr_kind_t k, input logic [15:0] d);
    @(posedge MCLK);
    CMD <= '{valid: 1'b1, write: wr, preset: pre, set: s, kind: k,
             data: d};
    @(posedge MCLK);
    CMD.valid <= 1'b0;
    CMD.data  <= ~d; // Stale data must not look like a valid word.
  endtask

  // Query and wait a bounded number of edges for the registered answer.
  task automatic query(input secr_set_t s, input secr_kind_t k,
                       output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    issue(1'b0, 1'b0, s, k, 16'h0000);
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge MCLK);
      if (RSP.valid === 1'b1) begin
        ok = 1'b1;
        d  = RSP.data;
      end
    end
  endtask
endmodule // secr_host

// file: test/status_enable_condition_regs_tb.sv
// Self-checking bench for the status enable and condition register bank.
// Assumes the host model drives commands; the bench drives live conditions.
module status_enable_condition_regs_tb
  import secr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  secr_cmd_t   cmd;
  secr_rsp_t   rsp;
  logic [15:0] cond [3] = '{16'h0000, 16'h0000, 16'h0000};
  wire  [2:0]  summ;
  int          failures = 0;
  int          total_checks = 0;
  logic [15:0] impl [3] = '{MEAS_MASK_IMPL, QUES_MASK_IMPL, OPER_MASK_IMPL};
  int          pos [3] = '{MEAS_TRACE_STORE_FULL, QUES_CALIBRATION, OPER_IDLE};

  // 20 MHz clock.
  always #25 mclk = ~mclk;

  secr_host host (.MCLK(mclk), .CMD(cmd), .RSP(rsp));

  secr_top DUT (
    .MCLK(mclk), .RESET(reset), .CMD(cmd), .RSP(rsp),
    .MEAS_COND(cond[0]), .QUES_COND(cond[1]), .OPER_COND(cond[2]),
    .MEAS_SUMMARY(summ[0]), .QUES_SUMMARY(summ[1]), .OPER_SUMMARY(summ[2])
  );

  // ==========================================================================
  // Reporting and comparisons
  // ==========================================================================
  // The single place where the run ends.
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare a returned register word.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a summary level.
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: summary %b expected %b", $time, got, exp);
    end
  endtask

  // Register accesses; a missing answer ends the run as a failure.
  task automatic wr(input int s, input logic [15:0] d);
    host.issue(1'b1, 1'b0, secr_set_t'(s), SECR_KIND_ENABLE, d);
  endtask

  task automatic rd(input int s, input secr_kind_t k, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    host.query(secr_set_t'(s), k, d, ok);
    if (!ok) begin
      failures++;
      $display("ERROR %0t: no answer", $time);
      finish_test();
    end else begin
      check_word(d, e);
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] b;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // Cleared state, full and empty masks, unused bits reading zero.
    for (int s = 0; s < 3; s++) begin
      rd(s, SECR_KIND_ENABLE, 16'h0000);
      rd(s, SECR_KIND_COND, 16'h0000);
      wr(s, 16'hffff);
      rd(s, SECR_KIND_ENABLE, impl[s]);
      wr(s, 16'h0000);
      rd(s, SECR_KIND_ENABLE, 16'h0000);
    end
    wr(0, 16'h0220);
    rd(0, SECR_KIND_ENABLE, 16'h0220);
    wr(0, 16'h0000);
    host.issue(1'b1, 1'b0, SECR_SET_MEAS, SECR_KIND_COND, 16'hffff);
    rd(0, SECR_KIND_COND, 16'h0000);
    rd(0, SECR_KIND_ENABLE, 16'h0000);
    rd(3, SECR_KIND_ENABLE, 16'h0000);
    // Masked event, then unmasked, then cleared by an event read.
    for (int s = 0; s < 3; s++) begin
      b = 16'h0001 << pos[s];
      @(posedge mclk);
      cond[s] <= b | ~impl[s];
      repeat (3) @(posedge mclk);
      rd(s, SECR_KIND_COND, b);
      rd(s, SECR_KIND_COND, b);
      check_bit(summ[s], 1'b0);
      wr(s, b);
      @(posedge mclk);
      check_bit(summ[s], 1'b1);
      rd(s, SECR_KIND_EVENT, b);
      @(posedge mclk);
      check_bit(summ[s], 1'b0);
      rd(s, SECR_KIND_EVENT, 16'h0000);
      cond[s] <= 16'h0000;
    end
    // Preset carrying a write clears only the masks.
    @(posedge mclk);
    cond[0] <= 16'h0200;
    for (int s = 0; s < 3; s++) wr(s, 16'hffff);
    host.issue(1'b1, 1'b1, SECR_SET_MEAS, SECR_KIND_ENABLE, 16'hffff);
    for (int s = 0; s < 3; s++) rd(s, SECR_KIND_ENABLE, 16'h0000);
    rd(0, SECR_KIND_COND, 16'h0200);
    rd(0, SECR_KIND_EVENT, 16'h0200);
    // A second reset clears a stored mask; then an enabled rise passes on.
    wr(1, 16'hffff);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(1, SECR_KIND_ENABLE, 16'h0000);
    rd(1, SECR_KIND_EVENT, 16'h0000);
    wr(2, 16'h0400);
    @(posedge mclk);
    cond[2] <= 16'h0400;
    repeat (2) @(posedge mclk);
    check_bit(summ[2], 1'b1);
    finish_test();
  end
endmodule // status_enable_condition_regs_tb
